// >>> inc/mac_half_decode_pkg.sv
`default_nettype none

package mac_half_decode_pkg;

   // Parallel-issue offset added to the single-issue opcode.
   localparam logic [31:0] PARALLEL_OFFSET = 32'h0800_0000;
   localparam int          PARALLEL_BIT    = 27;
   localparam logic [3:0]  FAMILY_NIBBLE   = 4'hC;

   // Upper-halfword opcodes.
   localparam logic [15:0] UP_ACC1_WIDE_MIXED = 16'hC072;
   localparam logic [15:0] UP_ACC0_DEFAULT    = 16'hC003;
   localparam logic [15:0] UP_ACC0_UFRAC      = 16'hC083;
   localparam logic [15:0] UP_ACC0_SINT       = 16'hC103;
   localparam logic [15:0] UP_ACC0_UINT       = 16'hC183;
   localparam logic [15:0] UP_ACC0_T          = 16'hC043;
   localparam logic [15:0] UP_ACC0_TUFRAC     = 16'hC0C3;
   localparam logic [15:0] UP_ACC0_S2         = 16'hC023;
   localparam logic [15:0] UP_ACC0_SINT_S2    = 16'hC123;
   localparam logic [15:0] UP_ACC0_HIEXT      = 16'hC163;
   localparam logic [15:0] UP_ACC1_LD_UFRAC   = 16'hC084;
   localparam logic [15:0] UP_ACC1_LD_SINT    = 16'hC104;
   localparam logic [15:0] UP_ACC1_LD_UINT    = 16'hC184;
   localparam logic [15:0] UP_ACC1_ADD_UFRAC  = 16'hC085;

   // Lower-halfword ranges, inclusive.
   localparam logic [15:0] LO_ACC1_ACC_MIN  = 16'h1800;
   localparam logic [15:0] LO_ACC1_ACC_MAX  = 16'hD83F;
   localparam logic [15:0] LO_LOAD_LO_MIN   = 16'h2000;
   localparam logic [15:0] LO_LOAD_LO_MAX   = 16'h27FF;
   localparam logic [15:0] LO_ADD_LO_MIN    = 16'h2800;
   localparam logic [15:0] LO_ADD_LO_MAX    = 16'h2FFF;
   localparam logic [15:0] LO_SUB_LO_MIN    = 16'h3000;
   localparam logic [15:0] LO_SUB_LO_MAX    = 16'h37FF;
   localparam logic [15:0] LO_HI_HALF_MIN   = 16'h1800;
   localparam logic [15:0] LO_HI_HALF_MAX   = 16'hD9FF;

   // Lower-halfword field positions.
   localparam logic [4:0] PAT_LOAD_LO = 5'h04;
   localparam logic [4:0] PAT_ADD_LO  = 5'h05;
   localparam int PAT_MSB  = 15;
   localparam int PAT_LSB  = 11;
   localparam int HALF_MSB = 10;
   localparam int HALF_LSB = 9;
   localparam int DST_MSB  = 8;
   localparam int DST_LSB  = 6;
   localparam int S0_MSB   = 5;
   localparam int S0_LSB   = 3;
   localparam int S1_MSB   = 2;
   localparam int S1_LSB   = 0;

   typedef enum logic [1:0] {OP_LOAD = 2'h0, OP_ADD = 2'h1, OP_SUB = 2'h2} mac_op_e;
   typedef enum logic [1:0] {DST_ACC_ONLY = 2'h0, DST_LOW_HALF = 2'h1, DST_HIGH_HALF = 2'h2} dst_half_e;
   typedef enum logic [3:0] {
      MODE_DEFAULT                           = 4'h0,
      MODE_UNSIGNED_FRACTION                 = 4'h1,
      MODE_SIGNED_INTEGER                    = 4'h2,
      MODE_UNSIGNED_INTEGER                  = 4'h3,
      MODE_TRUNCATED_SIGNED_FRACTION         = 4'h4,
      MODE_TRUNCATED_UNSIGNED_FRACTION       = 4'h5,
      MODE_SCALE_BY_TWO_ROUNDING             = 4'h6,
      MODE_SIGNED_INTEGER_SCALED             = 4'h7,
      MODE_INTEGER_HIGH_EXTRACTION           = 4'h8,
      MODE_WIDE_SATURATION                   = 4'h9
   } mac_mode_e;

   typedef struct packed {
      mac_op_e   op;
      logic      second_accumulator;
      mac_mode_e mode;
      logic      mixed_sign;
      dst_half_e dst_half;
      logic [1:0] half_sel;
      logic [2:0] dst_reg;
      logic [2:0] src0_reg;
      logic [2:0] src1_reg;
      logic      parallel;
   } mac_cmd_s;

endpackage
`default_nettype wire

// >>> src/mac_half_register_opcode_decode.sv
// Functional notes
// - A word carrying the parallel-issue offset decodes as the same operation as the single-issue word.
// - Words 0xC0721800..0xC072D83F load the second accumulator in wide saturation with mixed-sign operands.
// - Load-first-accumulator-to-low-half uses low range 0x2000..0x27FF with uppers C003, C083 and C103.
// - The same form also takes uppers C043, C0C3 and C023 for the truncated and scaled modes.
// - The same form also takes uppers C123 (scaled signed integer) and C163 (high extraction).
// - The load-to-low-half low halfword starts with 00100, then half selects, destination and sources.
// - Add-to-first-accumulator-to-low-half uses low range 0x2800..0x2FFF with uppers C003 and C083.
// - The add-to-low-half low halfword starts with 00101, then half selects, destination and sources.
// - Subtract-to-low-half uses low range 0x3000..0x37FF with uppers C103, C183 and C0C3.
// - Load-second-accumulator-to-high-half uses low range 0x1800..0xD9FF with uppers C084, C104, C184.
// - Add-to-second-accumulator-to-high-half uses upper C085 with low range 0x1800..0xD9FF.
`timescale 1ns/1ps
`default_nettype none

module mac_half_register_opcode_decode (
   // Clock and reset
   input  wire logic                       core_clk,
   input  wire logic                       resetn,
   // Fetch side
   input  wire logic                       fetch_valid,
   input  wire logic [31:0]                fetch_word,
   // Datapath side
   output logic                            issue_valid,
   output mac_half_decode_pkg::mac_cmd_s   issue_cmd,
   output logic                            illegal_instr
);
   import mac_half_decode_pkg::*;

   logic [31:0] base_word;
   logic [15:0] up;
   logic [15:0] lo;
   logic        in_family;
   logic        hit;
   mac_cmd_s    next_cmd;

   // The parallel form differs only in one opcode bit, so it is folded away here.
   assign base_word = fetch_word & ~PARALLEL_OFFSET;
   assign up        = base_word[31:16];
   assign lo        = base_word[15:0];
   assign in_family = (base_word[31:28] == FAMILY_NIBBLE);

   function automatic logic in_rng(input logic [15:0] v, input logic [15:0] lo_b, input logic [15:0] hi_b);
      in_rng = (v >= lo_b) && (v <= hi_b);
   endfunction

   always_comb begin
      hit                         = 1'b0;
      next_cmd                    = '0;
      next_cmd.parallel           = fetch_word[PARALLEL_BIT];
      next_cmd.half_sel           = lo[HALF_MSB:HALF_LSB];
      next_cmd.dst_reg            = lo[DST_MSB:DST_LSB];
      next_cmd.src0_reg           = lo[S0_MSB:S0_LSB];
      next_cmd.src1_reg           = lo[S1_MSB:S1_LSB];
      if (up == UP_ACC1_WIDE_MIXED && in_rng(lo, LO_ACC1_ACC_MIN, LO_ACC1_ACC_MAX)) begin
         hit                         = 1'b1;
         next_cmd.op                 = OP_LOAD;
         next_cmd.second_accumulator = 1'b1;
         next_cmd.mode               = MODE_WIDE_SATURATION;
         next_cmd.mixed_sign         = 1'b1;
         next_cmd.dst_half           = DST_ACC_ONLY;
      end else if (in_rng(lo, LO_LOAD_LO_MIN, LO_LOAD_LO_MAX) && lo[PAT_MSB:PAT_LSB] == PAT_LOAD_LO) begin
         next_cmd.op       = OP_LOAD;
         next_cmd.dst_half = DST_LOW_HALF;
         hit               = 1'b1;
         case (up)
            UP_ACC0_DEFAULT: next_cmd.mode = MODE_DEFAULT;
            UP_ACC0_UFRAC:   next_cmd.mode = MODE_UNSIGNED_FRACTION;
            UP_ACC0_SINT:    next_cmd.mode = MODE_SIGNED_INTEGER;
            UP_ACC0_T:       next_cmd.mode = MODE_TRUNCATED_SIGNED_FRACTION;
            UP_ACC0_TUFRAC:  next_cmd.mode = MODE_TRUNCATED_UNSIGNED_FRACTION;
            UP_ACC0_S2:      next_cmd.mode = MODE_SCALE_BY_TWO_ROUNDING;
            UP_ACC0_SINT_S2: next_cmd.mode = MODE_SIGNED_INTEGER_SCALED;
            UP_ACC0_HIEXT:   next_cmd.mode = MODE_INTEGER_HIGH_EXTRACTION;
            default:         hit           = 1'b0;
         endcase
      end else if (in_rng(lo, LO_ADD_LO_MIN, LO_ADD_LO_MAX) && lo[PAT_MSB:PAT_LSB] == PAT_ADD_LO) begin
         next_cmd.op       = OP_ADD;
         next_cmd.dst_half = DST_LOW_HALF;
         hit               = 1'b1;
         case (up)
            UP_ACC0_DEFAULT: next_cmd.mode = MODE_DEFAULT;
            UP_ACC0_UFRAC:   next_cmd.mode = MODE_UNSIGNED_FRACTION;
            default:         hit           = 1'b0;
         endcase
      end else if (in_rng(lo, LO_SUB_LO_MIN, LO_SUB_LO_MAX)) begin
         next_cmd.op       = OP_SUB;
         next_cmd.dst_half = DST_LOW_HALF;
         hit               = 1'b1;
         case (up)
            UP_ACC0_SINT:   next_cmd.mode = MODE_SIGNED_INTEGER;
            UP_ACC0_UINT:   next_cmd.mode = MODE_UNSIGNED_INTEGER;
            UP_ACC0_TUFRAC: next_cmd.mode = MODE_TRUNCATED_UNSIGNED_FRACTION;
            default:        hit           = 1'b0;
         endcase
      end
      // The high-half range overlaps the ones above, so it is tried by opcode only when nothing matched.
      if (!hit && in_rng(lo, LO_HI_HALF_MIN, LO_HI_HALF_MAX)) begin
         next_cmd.second_accumulator = 1'b1;
         next_cmd.dst_half           = DST_HIGH_HALF;
         next_cmd.mixed_sign         = 1'b0;
         hit                         = 1'b1;
         case (up)
            UP_ACC1_LD_UFRAC:  begin
               next_cmd.op   = OP_LOAD;
               next_cmd.mode = MODE_UNSIGNED_FRACTION;
            end
            UP_ACC1_LD_SINT:   begin
               next_cmd.op   = OP_LOAD;
               next_cmd.mode = MODE_SIGNED_INTEGER;
            end
            UP_ACC1_LD_UINT:   begin
               next_cmd.op   = OP_LOAD;
               next_cmd.mode = MODE_UNSIGNED_INTEGER;
            end
            UP_ACC1_ADD_UFRAC: begin
               next_cmd.op   = OP_ADD;
               next_cmd.mode = MODE_UNSIGNED_FRACTION;
            end
            default:        hit = 1'b0;
         endcase
      end
   end

   // Issue path: one cycle from the accepted fetch word.
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         issue_valid <= 1'b0;
         issue_cmd   <= '0;
      end else begin
         issue_valid <= fetch_valid && hit;
         if (fetch_valid && hit) begin
            issue_cmd <= next_cmd;
         end
      end
   end

   // Illegal flag: a family word that no decode row claims never reaches the datapath.
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         illegal_instr <= 1'b0;
      end else begin
         illegal_instr <= fetch_valid && in_family && !hit;
      end
   end

   sequence s_word(logic [15:0] u, logic [15:0] l_min, logic [15:0] l_max);
      fetch_valid && up == u && lo >= l_min && lo <= l_max;
   endsequence

   property p_parallel;
      @(posedge core_clk) disable iff (!resetn)
      fetch_valid ##1 issue_valid |-> issue_cmd.parallel == $past(fetch_word[PARALLEL_BIT]);
   endproperty
   a_parallel: assert property (p_parallel) else $error("parallel flag mismatch");

   property p_wide_mixed;
      @(posedge core_clk) disable iff (!resetn)
      s_word(UP_ACC1_WIDE_MIXED, LO_ACC1_ACC_MIN, LO_ACC1_ACC_MAX) |=> issue_valid
         && issue_cmd.mode == MODE_WIDE_SATURATION && issue_cmd.mixed_sign && issue_cmd.second_accumulator;
   endproperty
   a_wide_mixed: assert property (p_wide_mixed) else $error("wide mixed form not issued");

   property p_load_lo_default;
      @(posedge core_clk) disable iff (!resetn)
      s_word(UP_ACC0_DEFAULT, LO_LOAD_LO_MIN, LO_LOAD_LO_MAX) |=> issue_valid
         && issue_cmd.op == OP_LOAD && issue_cmd.dst_half == DST_LOW_HALF && !issue_cmd.second_accumulator;
   endproperty
   a_load_lo_default: assert property (p_load_lo_default) else $error("low-half load not issued");

   property p_load_lo_s2;
      @(posedge core_clk) disable iff (!resetn)
      s_word(UP_ACC0_S2, LO_LOAD_LO_MIN, LO_LOAD_LO_MAX) |=> issue_cmd.mode == MODE_SCALE_BY_TWO_ROUNDING;
   endproperty
   a_load_lo_s2: assert property (p_load_lo_s2) else $error("scale-by-two mode wrong");

   property p_load_lo_hiext;
      @(posedge core_clk) disable iff (!resetn)
      s_word(UP_ACC0_HIEXT, LO_LOAD_LO_MIN, LO_LOAD_LO_MAX) |=> issue_cmd.mode == MODE_INTEGER_HIGH_EXTRACTION;
   endproperty
   a_load_lo_hiext: assert property (p_load_lo_hiext) else $error("high extraction mode wrong");

   property p_fields;
      @(posedge core_clk) disable iff (!resetn)
      fetch_valid ##1 issue_valid |-> issue_cmd.dst_reg == $past(fetch_word[DST_MSB:DST_LSB])
         && issue_cmd.src1_reg == $past(fetch_word[S1_MSB:S1_LSB]);
   endproperty
   a_fields: assert property (p_fields) else $error("register fields mismatch");

   property p_add_lo;
      @(posedge core_clk) disable iff (!resetn)
      s_word(UP_ACC0_UFRAC, LO_ADD_LO_MIN, LO_ADD_LO_MAX) |=> issue_valid && issue_cmd.op == OP_ADD
         && issue_cmd.mode == MODE_UNSIGNED_FRACTION;
   endproperty
   a_add_lo: assert property (p_add_lo) else $error("low-half add not issued");

   property p_sub_lo;
      @(posedge core_clk) disable iff (!resetn)
      s_word(UP_ACC0_UINT, LO_SUB_LO_MIN, LO_SUB_LO_MAX) |=> issue_valid && issue_cmd.op == OP_SUB
         && issue_cmd.mode == MODE_UNSIGNED_INTEGER;
   endproperty
   a_sub_lo: assert property (p_sub_lo) else $error("low-half subtract not issued");

   property p_hi_half;
      @(posedge core_clk) disable iff (!resetn)
      s_word(UP_ACC1_ADD_UFRAC, LO_HI_HALF_MIN, LO_HI_HALF_MAX) |=> issue_valid && issue_cmd.op == OP_ADD
         && issue_cmd.dst_half == DST_HIGH_HALF;
   endproperty
   a_hi_half: assert property (p_hi_half) else $error("high-half add not issued");

   property p_hi_half_load;
      @(posedge core_clk) disable iff (!resetn)
      s_word(UP_ACC1_LD_UINT, LO_HI_HALF_MIN, LO_HI_HALF_MAX) |=> issue_valid && issue_cmd.op == OP_LOAD
         && issue_cmd.mode == MODE_UNSIGNED_INTEGER && issue_cmd.second_accumulator;
   endproperty
   a_hi_half_load: assert property (p_hi_half_load) else $error("high-half load not issued");

   property p_illegal;
      @(posedge core_clk) disable iff (!resetn)
      illegal_instr |-> !issue_valid && $past(fetch_valid) && $past(fetch_word[31:28]) == FAMILY_NIBBLE;
   endproperty
   a_illegal: assert property (p_illegal) else $error("illegal word issued");

endmodule // mac_half_register_opcode_decode
`default_nettype wire

// >>> verif/mac_datapath_model.sv
`timescale 1ns/1ps
`default_nettype none

module mac_datapath_model (
   // Clock
   input  wire logic                          core_clk,
   // Decoder side
   input  wire logic                          issue_valid,
   input  wire mac_half_decode_pkg::mac_cmd_s issue_cmd,
   // Bench side
   output logic [31:0]                        issue_count,
   output logic [31:0]                        parallel_count
);
   import mac_half_decode_pkg::*;

   // Counts never clear and ignore reset, so an operation leaking out during reset still shows.
   logic [31:0] issues_seen   = 32'h0;
   logic [31:0] parallel_seen = 32'h0;

   assign issue_count    = issues_seen;
   assign parallel_count = parallel_seen;

   always @(posedge core_clk) begin
      if (issue_valid === 1'b1) begin
         issues_seen <= issues_seen + 32'h1;
         if (issue_cmd.parallel === 1'b1) parallel_seen <= parallel_seen + 32'h1;
      end
   end
endmodule  // mac_datapath_model
`default_nettype wire

// >>> verif/mac_half_register_opcode_decode_tb.sv
`timescale 1ns/1ps
`default_nettype none

module mac_half_register_opcode_decode_tb;
   import mac_half_decode_pkg::*;

   logic        core_clk, resetn, fetch_valid, issue_valid, illegal_instr;
   logic [31:0] fetch_word, model_issues, model_parallel, exp_issues, exp_parallel;
   logic        exp_v, exp_ill, t_v, t_ill;
   mac_cmd_s    issue_cmd, exp_cmd, t_cmd;
   int          num_errors, check_count, cycles;
   localparam logic [15:0] UPS[14] = '{16'hC072, 16'hC003, 16'hC083, 16'hC103, 16'hC183, 16'hC043, 16'hC0C3,
                                       16'hC023, 16'hC123, 16'hC163, 16'hC084, 16'hC104, 16'hC184, 16'hC085};
   localparam logic [15:0] LOS[14] = '{16'h17FF, 16'h1800, 16'h1FFF, 16'h2000, 16'h27FF, 16'h2800, 16'h2FFF,
                                       16'h3000, 16'h37FF, 16'h3800, 16'hD83F, 16'hD840, 16'hD9FF, 16'hDA00};

   mac_half_register_opcode_decode DUT (.core_clk(core_clk), .resetn(resetn), .fetch_valid(fetch_valid),
      .fetch_word(fetch_word), .issue_valid(issue_valid), .issue_cmd(issue_cmd), .illegal_instr(illegal_instr));
   mac_datapath_model partner (.core_clk(core_clk), .issue_valid(issue_valid),
      .issue_cmd(issue_cmd), .issue_count(model_issues), .parallel_count(model_parallel));

   initial begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end

   function automatic mac_mode_e mode_of(input logic [15:0] up);
      case (up[11:4])
         8'h08: return MODE_UNSIGNED_FRACTION;
         8'h10: return MODE_SIGNED_INTEGER;
         8'h18: return MODE_UNSIGNED_INTEGER;
         8'h04: return MODE_TRUNCATED_SIGNED_FRACTION;
         8'h0C: return MODE_TRUNCATED_UNSIGNED_FRACTION;
         8'h02: return MODE_SCALE_BY_TWO_ROUNDING;
         8'h12: return MODE_SIGNED_INTEGER_SCALED;
         8'h16: return MODE_INTEGER_HIGH_EXTRACTION;
         default: return MODE_DEFAULT;
      endcase
   endfunction

   function automatic void expect_word(input logic [31:0] word, output logic v, output logic ill, output mac_cmd_s c);
      logic [31:0] w;
      logic        hit;
      w = word & ~PARALLEL_OFFSET;
      c = '0;
      hit = 1'b1;
      c.dst_half = DST_LOW_HALF;
      c.mode = mode_of(w[31:16]);
      if (w[31:16] == 16'hC072 && w[15:0] inside {[16'h1800:16'hD83F]}) begin
         c.second_accumulator = 1'b1;
         c.mode = MODE_WIDE_SATURATION;
         c.mixed_sign = 1'b1;
         c.dst_half = DST_ACC_ONLY;
      end else if (w[15:0] inside {[16'h2000:16'h27FF]} && w[31:16] inside {16'hC003, 16'hC083, 16'hC103,
                   16'hC043, 16'hC0C3, 16'hC023, 16'hC123, 16'hC163}) begin
         c.op = OP_LOAD;
      end else if (w[15:0] inside {[16'h2800:16'h2FFF]} && w[31:16] inside {16'hC003, 16'hC083}) begin
         c.op = OP_ADD;
      end else if (w[15:0] inside {[16'h3000:16'h37FF]} && w[31:16] inside {16'hC103, 16'hC183, 16'hC0C3}) begin
         c.op = OP_SUB;
      end else if (w[15:0] inside {[16'h1800:16'hD9FF]} && w[31:16] inside {16'hC084, 16'hC104, 16'hC184, 16'hC085}) begin
         c.op = (w[31:16] == 16'hC085) ? OP_ADD : OP_LOAD;
         c.second_accumulator = 1'b1;
         c.dst_half = DST_HIGH_HALF;
      end else begin
         hit = 1'b0;
      end
      c.half_sel = w[10:9];
      c.dst_reg = w[8:6];
      c.src0_reg = w[5:3];
      c.src1_reg = w[2:0];
      c.parallel = word[27];
      v = hit;
      ill = (w[31:28] == 4'hC) && !hit;
   endfunction

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic print_verdict();
      $display("checks %0d errors %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic send(input logic [31:0] w, input logic v);
      @(posedge core_clk);
      fetch_word <= w;
      fetch_valid <= v;
   endtask

   // The bench keeps its own copy of what the decoder should answer one edge later.
   always @(posedge core_clk) begin
      cycles++;
      if (cycles >= 10000) begin
         num_errors++;
         print_verdict();
      end
      expect_word(fetch_word, t_v, t_ill, t_cmd);
      if (resetn !== 1'b1) begin
         exp_v <= 1'b0;
         exp_ill <= 1'b0;
         exp_cmd <= '0;
      end else begin
         exp_v <= fetch_valid & t_v;
         exp_ill <= fetch_valid & t_ill;
         if (fetch_valid & t_v) exp_cmd <= t_cmd;
      end
   end

   always @(negedge core_clk) begin
      if (cycles > 1) begin
         check("issue_valid", {31'h0, issue_valid}, {31'h0, exp_v});
         check("illegal_instr", {31'h0, illegal_instr}, {31'h0, exp_ill});
         check("issue_cmd", 32'(issue_cmd), 32'(exp_cmd));
         if (exp_v === 1'b1) exp_issues++;
         if (exp_v === 1'b1 && exp_cmd.parallel === 1'b1) exp_parallel++;
      end
   end

   initial begin
      int          i;
      logic [31:0] w;
      resetn = 1'b0;
      fetch_valid = 1'b0;
      fetch_word = 32'h0;
      {num_errors, check_count, cycles} = '0;
      {exp_issues, exp_parallel} = '0;
      void'($urandom(32'h372C1F61));
      repeat (16) @(posedge core_clk);
      resetn <= 1'b1;
      send(32'h0, 1'b0);
      // Every upper halfword against every range edge, single and parallel issue, back to back.
      for (i = 0; i < 392; i++) send({UPS[i / 28], LOS[i % 14]} | ((i % 28) >= 14 ? PARALLEL_OFFSET : 32'h0), 1'b1);
      send(32'h30032000, 1'b1);
      send(32'hFFFFFFFF, 1'b1);
      send(32'hC0FF2000, 1'b1);
      // Reset in mid-stream drops the words presented meanwhile.
      @(posedge core_clk) resetn <= 1'b0;
      repeat (3) send(32'hC0832000, 1'b1);
      @(posedge core_clk) resetn <= 1'b1;
      fetch_valid <= 1'b0;
      for (i = 0; i < 3000; i++) begin
         w = $urandom();
         if (w[1:0] != 2'h0) w[31:16] = UPS[$urandom_range(13)];
         w[27] = 1'($urandom_range(1));
         send(w, $urandom_range(4) != 0);
      end
      send(32'h0, 1'b0);
      repeat (3) @(posedge core_clk);
      check("issue count", model_issues, exp_issues);
      check("parallel count", model_parallel, exp_parallel);
      print_verdict();
   end
endmodule  // mac_half_register_opcode_decode_tb
`default_nettype wire
